// ### psm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module psm_cpu_model (
  // Core clock and state
  input  wire logic clk,
  input  wire logic halt,
  // Instruction strobes
  output var  logic wait_instr,
  output var  logic stop_instr
);
  initial begin
    wait_instr = 1'b0;
    stop_instr = 1'b0;
  end
  // A halted core fetches nothing, so an instruction only issues from RUN
  task automatic exec(input bit stop);
    @(posedge clk);
    while (halt !== 1'b0) @(posedge clk);
    wait_instr <= !stop;
    stop_instr <= stop;
    @(posedge clk);
    wait_instr <= 1'b0;
    stop_instr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### psm_mode_chk.sv
`timescale 1ns/1ps
`default_nettype none
module psm_mode_chk #(parameter STARTUP_CYC = 16) (
  // Clock, reset and wake sources
  input wire logic       SYS_CLK, SRST, WDG_RESET, LVD_RESET, PIN_RESET, NMI_PIN,
  input wire logic       PORTA_IRQ, PORTBC_IRQ, TIMER_ZERO_FLAG, WDG_ACTIVE,
  input wire logic [3:0] IRQ_ENABLE,
  // Core side
  input wire logic       WAIT_INSTR, STOP_INSTR, CPU_HALT, OSC_RUN, PC_LOAD,
  input wire logic [1:0] MODE
);
  int  cnt_q;
  wire any_wake = WDG_RESET | LVD_RESET | PIN_RESET | NMI_PIN | PORTA_IRQ | PORTBC_IRQ | TIMER_ZERO_FLAG;
  // Counts startup cycles; cleared by the mode itself, so a reset needs no extra path
  always @(posedge SYS_CLK) cnt_q <= (MODE == 2'h3) ? cnt_q + 1 : 0;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  a_wait_cause: assert property (
    MODE == 2'h1 && $past(MODE) == 2'h0 |-> $past(WAIT_INSTR) || $past(STOP_INSTR && WDG_ACTIVE))
    else $error("wait entered without cause");
  a_stop_cause: assert property (
    MODE == 2'h2 && $past(MODE) == 2'h0 |-> $past(STOP_INSTR) && (!$past(WDG_ACTIVE) || $past(NMI_PIN)))
    else $error("stop entered without cause");
  a_halt_mode: assert property (CPU_HALT == (MODE != 2'h0))
    else $error("halt disagrees with mode");
  a_osc_stop: assert property (OSC_RUN == (MODE != 2'h2))
    else $error("oscillator state wrong");
  a_stop_exit: assert property (
    $past(MODE) == 2'h2 && MODE != 2'h2 && !$past(SRST) |-> MODE == 2'h3)
    else $error("stop left without startup");
  a_startup_len: assert property (
    $past(MODE) == 2'h3 && MODE == 2'h0 && !$past(SRST) |-> cnt_q == STARTUP_CYC)
    else $error("startup length wrong");
  a_resume_load: assert property (
    $past(MODE) == 2'h3 && MODE == 2'h0 && !$past(SRST) |-> ##[0:1] PC_LOAD)
    else $error("no vector load after startup");
  a_load_pulse: assert property (PC_LOAD |=> !PC_LOAD)
    else $error("vector load not a pulse");
  a_stop_hold: assert property ((MODE == 2'h2 && !any_wake)[*4] |=> MODE == 2'h2)
    else $error("stop left without wake source");
  a_timer_wake: assert property (
    MODE == 2'h2 && TIMER_ZERO_FLAG && IRQ_ENABLE[2] |-> ##[1:4] MODE == 2'h3)
    else $error("timer did not wake stop");
  a_wait_wake: assert property (
    MODE == 2'h1 && PORTA_IRQ && IRQ_ENABLE[0] |-> ##[1:4] MODE == 2'h0)
    else $error("port did not wake wait");
endmodule
bind psm_mode_ctrl psm_mode_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (.SYS_CLK, .SRST, .WDG_RESET, .LVD_RESET,
  .PIN_RESET, .NMI_PIN, .PORTA_IRQ, .PORTBC_IRQ, .TIMER_ZERO_FLAG, .WDG_ACTIVE, .IRQ_ENABLE, .WAIT_INSTR,
  .STOP_INSTR, .CPU_HALT, .OSC_RUN, .PC_LOAD, .MODE);
`default_nettype wire

// ### psm_mode_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.vh"
module psm_mode_ctrl #(
  parameter STARTUP_CYC = `PSM_STARTUP_CYC
) (
  // Clock and reset
  input  wire        SYS_CLK,
  input  wire        SRST,
  // Reset sources (pins, asynchronous)
  input  wire        WDG_RESET,
  input  wire        LVD_RESET,
  input  wire        PIN_RESET,
  // Watchdog state
  input  wire        WDG_ACTIVE,
  // Interrupt requests (pins, asynchronous)
  input  wire        NMI_PIN,
  input  wire        PORTA_IRQ,
  input  wire        PORTBC_IRQ,
  input  wire        TIMER_ZERO_FLAG,
  input  wire        ADC_EOC_IRQ,
  input  wire [3:0]  IRQ_ENABLE,
  // CPU instruction strobes
  input  wire        WAIT_INSTR,
  input  wire        STOP_INSTR,
  // Register port
  input  wire [3:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [7:0]  REG_RDATA,
  // Clock and CPU control
  output reg         CPU_HALT,
  output reg         OSC_RUN,
  output reg         LOW_FREQ_AUX_OSC,
  output reg         WDG_FREEZE,
  output reg  [1:0]  MODE,
  output reg         PC_LOAD,
  output reg  [11:0] PC_VECTOR,
  output reg         IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam NSYNC = 8;
  wire [NSYNC-1:0] raw_in = {ADC_EOC_IRQ, TIMER_ZERO_FLAG, PORTBC_IRQ, PORTA_IRQ,
                              NMI_PIN, PIN_RESET, LVD_RESET, WDG_RESET};
  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      sync1_q <= {NSYNC{1'b0}};
      sync2_q <= {NSYNC{1'b0}};
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end
  wire any_rst  = |sync2_q[2:0];
  wire nmi      = sync2_q[3];
  wire irq_pa   = sync2_q[4] & IRQ_ENABLE[0];
  wire irq_pbc  = sync2_q[5] & IRQ_ENABLE[1];
  wire irq_tmr  = sync2_q[6] & IRQ_ENABLE[2];
  wire irq_adc  = sync2_q[7] & IRQ_ENABLE[3];

  ////////////////////////////////////////////////////////////////////////
  // Control register
  reg [7:0] ctrl_q;
  reg [`PSM_EV_W-1:0] stat_q;
  reg [`PSM_EV_W-1:0] mask_q;
  wire gie = ctrl_q[`PSM_CTRL_GIE];
  wire opt = ctrl_q[`PSM_CTRL_OPTION];

  // Wake source selection, highest priority first
  function [12:0] pick_vec;
    input rst_i;
    input nmi_i;
    input pa_i;
    input pbc_i;
    input tmr_i;
    input adc_i;
    begin
      if (rst_i)
        pick_vec = {1'b1, `PSM_VEC_RESET};
      else if (nmi_i)
        pick_vec = {1'b1, `PSM_VEC_NMI};
      else if (pa_i)
        pick_vec = {1'b1, `PSM_VEC_PORTA};
      else if (pbc_i)
        pick_vec = {1'b1, `PSM_VEC_PORTBC};
      else if (tmr_i)
        pick_vec = {1'b1, `PSM_VEC_TIMER};
      else if (adc_i)
        pick_vec = {1'b1, `PSM_VEC_ADC};
      else
        pick_vec = 13'h0000;
    end
  endfunction

  // NMI is gated by the global enable in both wake paths and in pending
  wire nmi_wake = nmi & gie;
  wire [12:0] wake_wait = pick_vec(any_rst, nmi_wake, irq_pa, irq_pbc, irq_tmr, irq_adc);
  // End-of-conversion cannot wake STOP: its clock is stopped
  wire [12:0] wake_stop = pick_vec(any_rst, nmi_wake, irq_pa, irq_pbc, irq_tmr, 1'b0);
  wire pending = irq_pa | irq_pbc | irq_tmr | irq_adc | nmi_wake;

  ////////////////////////////////////////////////////////////////////////
  // Mode state machine
  reg [1:0]             mode_q;
  reg [1:0]             mode_d;
  reg [`PSM_CNT_W-1:0]  cnt_q;
  reg [11:0]            vec_q;
  reg                   wdg_frz_q;
  reg                   ev_wait;
  reg                   ev_stop;
  reg                   ev_wake;
  reg                   ev_resume;
  reg                   pc_load_d;
  wire stop_ok = ~WDG_ACTIVE | (opt & nmi);
  // Cut to the counter width on purpose; STARTUP_CYC must fit in it
  wire [`PSM_CNT_W-1:0] last_cnt = STARTUP_CYC[`PSM_CNT_W-1:0] - 1'b1;

  always @* begin
    mode_d    = mode_q;
    ev_wait   = 1'b0;
    ev_stop   = 1'b0;
    ev_wake   = 1'b0;
    ev_resume = 1'b0;
    pc_load_d = 1'b0;
    case (mode_q)
      `PSM_MODE_RUN: begin
        if (any_rst) begin
          mode_d = `PSM_MODE_RUN;
        end else if (STOP_INSTR & ~pending) begin
          if (stop_ok) begin
            mode_d  = `PSM_MODE_STOP;
            ev_stop = 1'b1;
          end else begin
            mode_d  = `PSM_MODE_WAIT;
            ev_wait = 1'b1;
          end
        end else if (WAIT_INSTR & ~pending) begin
          mode_d  = `PSM_MODE_WAIT;
          ev_wait = 1'b1;
        end
      end
      `PSM_MODE_WAIT: begin
        if (wake_wait[12]) begin
          mode_d    = `PSM_MODE_RUN;
          ev_wake   = 1'b1;
          pc_load_d = 1'b1;
        end
      end
      `PSM_MODE_STOP: begin
        if (wake_stop[12]) begin
          mode_d  = `PSM_MODE_START;
          ev_wake = 1'b1;
        end
      end
      `PSM_MODE_START: begin
        if (cnt_q == last_cnt) begin
          mode_d    = `PSM_MODE_RUN;
          ev_resume = 1'b1;
          pc_load_d = 1'b1;
        end
      end
      default: mode_d = `PSM_MODE_RUN;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      mode_q    <= `PSM_MODE_RUN;
      cnt_q     <= {`PSM_CNT_W{1'b0}};
      vec_q     <= `PSM_VEC_RESET;
      wdg_frz_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      // Counter only runs during start-up so it restarts on every exit
      if (mode_q == `PSM_MODE_START)
        cnt_q <= cnt_q + 1'b1;
      else
        cnt_q <= {`PSM_CNT_W{1'b0}};
      if (mode_q == `PSM_MODE_WAIT && wake_wait[12])
        vec_q <= wake_wait[11:0];
      else if (mode_q == `PSM_MODE_STOP && wake_stop[12])
        vec_q <= wake_stop[11:0];
      if (ev_stop)
        wdg_frz_q <= WDG_ACTIVE;
      else if (mode_d == `PSM_MODE_RUN)
        wdg_frz_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and interrupt
  wire [`PSM_EV_W-1:0] ev = {ev_resume, ev_wake, ev_stop, ev_wait};
  wire rd_stat = REG_RD && (REG_ADDR == `PSM_A_IRQ_STAT);

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl_q    <= 8'h00;
      stat_q    <= {`PSM_EV_W{1'b0}};
      mask_q    <= {`PSM_EV_W{1'b0}};
      REG_RDATA <= 8'h00;
    end else begin
      if (REG_WR && REG_ADDR == `PSM_A_CTRL)
        ctrl_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == `PSM_A_IRQ_MASK)
        mask_q <= REG_WDATA[`PSM_EV_W-1:0];
      // New events win over the clear-on-read
      stat_q <= (rd_stat ? {`PSM_EV_W{1'b0}} : stat_q) | ev;
      REG_RDATA <= 8'h00;
      if (REG_RD) begin
        case (REG_ADDR)
          `PSM_A_CTRL:      REG_RDATA <= ctrl_q;
          `PSM_A_STATUS:    REG_RDATA <= {3'h0, wdg_frz_q, OSC_RUN, CPU_HALT, mode_q};
          `PSM_A_IRQ_STAT:  REG_RDATA <= {4'h0, stat_q};
          `PSM_A_IRQ_MASK:  REG_RDATA <= {4'h0, mask_q};
          `PSM_A_VECTOR:    REG_RDATA <= vec_q[7:0];
          `PSM_A_VECTOR_HI: REG_RDATA <= {4'h0, vec_q[11:8]};
          default:          REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Peripheral state is untouched here; only the CPU is halted and, in STOP, the
  // oscillator stopped and an active watchdog frozen, so RAM and registers keep their values in both sleep modes.
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      CPU_HALT         <= 1'b0;
      OSC_RUN          <= 1'b1;
      LOW_FREQ_AUX_OSC <= 1'b0;
      WDG_FREEZE       <= 1'b0;
      MODE             <= `PSM_MODE_RUN;
      PC_LOAD          <= 1'b0;
      PC_VECTOR        <= `PSM_VEC_RESET;
      IRQ              <= 1'b0;
    end else begin
      CPU_HALT         <= (mode_d != `PSM_MODE_RUN);
      OSC_RUN          <= (mode_d != `PSM_MODE_STOP);
      LOW_FREQ_AUX_OSC <= ctrl_q[`PSM_CTRL_LOW_FREQ_AUX_OSC];
      WDG_FREEZE       <= wdg_frz_q;
      MODE             <= mode_d;
      PC_LOAD          <= pc_load_d;
      if (mode_q == `PSM_MODE_WAIT && wake_wait[12])
        PC_VECTOR <= wake_wait[11:0];
      else if (mode_q == `PSM_MODE_START)
        PC_VECTOR <= vec_q;
      IRQ <= |(((rd_stat ? {`PSM_EV_W{1'b0}} : stat_q) | ev) & mask_q);
    end
  end

endmodule
`default_nettype wire

// ### psm_regs.vh
//
// Contract
// - After any reset the block sits in RUN with the main oscillator driving the clock (WDG, LVD and pin resets leave LOW_FREQ_AUX_OSC as it was).
// - Sleep modes come from CPU instructions; auxiliary oscillator selection from a register bit.
// - A wait instruction enters WAIT at once, CPU halted.
// - WAIT keeps RAM and peripheral registers unchanged.
// - WAIT keeps the active oscillator running so peripherals stay clocked.
// - WAIT ends on any reset, any peripheral interrupt, port or non-maskable interrupt.
// - Leaving WAIT, the program counter loads the vector of the waking source.
// - A stop instruction halts the CPU and the oscillator at once.
// - STOP keeps RAM and peripheral registers.
// - STOP ends only on reset, port or non-maskable interrupt, externally clocked peripheral.
// - Every STOP exit waits 2048 internal clock cycles before resuming.
// - After that delay the program counter holds the waking source's vector.
// - With watchdog active, stop acts as wait unless option bit and NMI pin high.
// - Only STOP-capable interrupt sources may wake the device from STOP.
// - With global interrupt enable low, NMI cannot wake from STOP or WAIT.
// - Wait or stop is not carried out while an enabled interrupt is pending.
//
`ifndef PSM_REGS_VH
`define PSM_REGS_VH
// Modes
`define PSM_MODE_RUN      2'h0
`define PSM_MODE_WAIT     2'h1
`define PSM_MODE_STOP     2'h2
`define PSM_MODE_START    2'h3
// Vectors
`define PSM_VEC_RESET     12'hFFE
`define PSM_VEC_NMI       12'hFFC
`define PSM_VEC_PORTA     12'hFF6
`define PSM_VEC_PORTBC    12'hFF4
`define PSM_VEC_TIMER     12'hFF2
`define PSM_VEC_ADC       12'hFF0
// Oscillator start-up delay
`define PSM_STARTUP_CYC   2048
`define PSM_CNT_W         12
// Register map
`define PSM_ADDR_W        4
`define PSM_A_CTRL        4'h0
`define PSM_A_STATUS      4'h1
`define PSM_A_IRQ_STAT    4'h2
`define PSM_A_IRQ_MASK    4'h3
`define PSM_A_VECTOR      4'h4
`define PSM_A_VECTOR_HI   4'h5
// Control bits
`define PSM_CTRL_LOW_FREQ_AUX_OSC     0
`define PSM_CTRL_GIE      1
`define PSM_CTRL_OPTION   2
// Event bits
`define PSM_EV_WAIT       0
`define PSM_EV_STOP       1
`define PSM_EV_WAKE       2
`define PSM_EV_RESUME     3
`define PSM_EV_W          4
`endif

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        SYS_CLK, SRST, WDG_ACTIVE, REG_WR, REG_RD, wait_i, stop_i;
  logic        CPU_HALT, OSC_RUN, LOW_FREQ_AUX_OSC, WDG_FREEZE, PC_LOAD, IRQ;
  logic [7:0]  src, REG_WDATA, REG_RDATA, seed, d;
  logic [3:0]  IRQ_ENABLE, REG_ADDR;
  logic [1:0]  MODE;
  logic [11:0] PC_VECTOR;
  logic [11:0] q[$];
  logic [11:0] vt [8] = '{12'hFFE, 12'hFFE, 12'hFFE, 12'hFFC, 12'hFF6, 12'hFF4, 12'hFF2, 12'hFF0};
  int          mismatches, total_checks;
  psm_mode_ctrl #(.STARTUP_CYC(16)) dut (.SYS_CLK, .SRST, .WDG_RESET(src[0]), .LVD_RESET(src[1]),
    .PIN_RESET(src[2]), .WDG_ACTIVE, .NMI_PIN(src[3]), .PORTA_IRQ(src[4]), .PORTBC_IRQ(src[5]),
    .TIMER_ZERO_FLAG(src[6]), .ADC_EOC_IRQ(src[7]), .IRQ_ENABLE, .WAIT_INSTR(wait_i), .STOP_INSTR(stop_i),
    .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .CPU_HALT, .OSC_RUN, .LOW_FREQ_AUX_OSC,
    .WDG_FREEZE, .MODE, .PC_LOAD, .PC_VECTOR, .IRQ);
  psm_cpu_model cpu (.clk(SYS_CLK), .halt(CPU_HALT), .wait_instr(wait_i), .stop_instr(stop_i));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(negedge SYS_CLK);
    d = REG_RDATA;
  endtask
  task automatic instr(input bit stop, input logic [1:0] m);
    cpu.exec(stop);
    @(negedge SYS_CLK);
    chk(MODE, m);
  endtask
  // The model queue holds the vector the raised source must produce
  task automatic wake(input int i, input int n);
    @(posedge SYS_CLK);
    src[i] <= 1'b1;
    q.push_back(vt[i]);
    repeat (n) begin
      @(negedge SYS_CLK);
      if (PC_LOAD === 1'b1) break;
    end
    chk(PC_LOAD, 12'h1);
    chk(PC_VECTOR, q.pop_front());
    @(posedge SYS_CLK);
    src[i] <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (3000) @(posedge SYS_CLK);
    mismatches++;
    stop_test();
  end
  initial begin
    {SRST, WDG_ACTIVE, REG_WR, REG_RD, src, REG_WDATA, REG_ADDR} = 0;
    SRST = 1'b1;
    IRQ_ENABLE = 4'hF;
    seed = 8'h5B;
    repeat (8) @(posedge SYS_CLK);
    SRST <= 1'b0;
    rd(4'h1);
    chk(d, 12'h08);
    seed = lfsr(seed);
    wr(4'hF, seed);
    rd(4'hF);
    chk(d, 12'h00);
    wr(4'h0, 8'h03);
    // Output flop follows the control register one cycle later
    repeat (2) @(negedge SYS_CLK);
    chk(LOW_FREQ_AUX_OSC, 12'h1);
    for (int i = 0; i < 8; i++) begin
      instr(0, 2'h1);
      chk(OSC_RUN, 12'h1);
      wake(i, 8);
    end
    chk(IRQ, 12'h0);
    wr(4'h3, 8'h0F);
    repeat (2) @(negedge SYS_CLK);
    chk(IRQ, 12'h1);
    rd(4'h2);
    repeat (2) @(negedge SYS_CLK);
    chk(IRQ, 12'h0);
    @(posedge SYS_CLK) src[4] <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    instr(0, 2'h0);
    @(posedge SYS_CLK) src[4] <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    instr(1, 2'h2);
    chk(OSC_RUN, 12'h0);
    @(posedge SYS_CLK) src[7] <= 1'b1;
    repeat (10) @(posedge SYS_CLK);
    src[7] <= 1'b0;
    @(negedge SYS_CLK);
    chk(MODE, 2'h2);
    wake(6, 40);
    rd(4'h2);
    chk(d, 12'h0E);
    @(posedge SYS_CLK) WDG_ACTIVE <= 1'b1;
    instr(1, 2'h1);
    wake(4, 8);
    wr(4'h0, 8'h05);
    @(posedge SYS_CLK) src[3] <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    instr(1, 2'h2);
    // Freeze output is one flop behind the internal freeze bit
    @(negedge SYS_CLK);
    chk(WDG_FREEZE, 12'h1);
    repeat (8) @(negedge SYS_CLK);
    chk(MODE, 2'h2);
    wake(6, 40);
    src[3] <= 1'b0;
    WDG_ACTIVE <= 1'b0;
    stop_test();
  end
endmodule
`default_nettype wire
